// ===== design/awu_prescaler.sv
// awu_prescaler.sv: rc start-up skip, fixed divide-by-64 and 8-bit
// programmable divide; pulses done once per halt unless run drops before the delay elapses.
// assumes: rc_tick is already in the clk domain, one cycle per rc edge.
`timescale 1ns/10ps
`include "awu_cfg.svh"
module awu_prescaler
#(
  parameter logic [7:0] START_TICKS = `AWU_RC_START_TICKS
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic       run,
  input  wire logic       rc_tick,
  input  wire logic [7:0] presc,
  output logic            done
);

  logic       active;
  logic [7:0] st_cnt;
  logic [5:0] div_cnt;
  logic [7:0] pre_cnt;

  wire starting = (st_cnt != START_TICKS);
  wire div_wrap = (div_cnt == 6'(`AWU_FIXED_DIV - 1));
  wire pre_last = (pre_cnt == presc);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      active  <= 1'b0;
      done    <= 1'b0;
      st_cnt  <= 8'h00;
      div_cnt <= 6'h00;
      pre_cnt <= 8'h01;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (!run)
        active <= 1'b0;
      else if (start)
      begin
        st_cnt  <= 8'h00;
        div_cnt <= 6'h00;
        pre_cnt <= 8'h01;
        // zero divide fires at once (only reachable in that variant)
        active  <= (presc != `AWU_PRESC_ZERO);
        done    <= (presc == `AWU_PRESC_ZERO);
      end
      else if (active && rc_tick)
      begin
        if (starting)
          st_cnt <= st_cnt + 8'h01;
        else
        begin
          div_cnt <= div_cnt + 6'h01;
          if (div_wrap)
          begin
            if (pre_last)
            begin
              done   <= 1'b1;
              active <= 1'b0;
            end
            else
              pre_cnt <= pre_cnt + 8'h01;
          end
        end
      end
    end
  end

endmodule

// ===== design/awu_sync_edge.sv
// awu_sync_edge.sv: two-flop synchroniser with rising-edge detect.
// assumes: the input may change at any time relative to clk.
`timescale 1ns/10ps
module awu_sync_edge
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);

  logic sync1;
  logic sync2;
  logic prev;

  // sync1 feeds only sync2 so a metastable sample never reaches logic
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev  <= 1'b0;
    end
    else if (ce)
    begin
      sync1 <= async_in;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign level = sync2;
  assign rise  = sync2 & ~prev;

endmodule

// ===== design/awu_top.sv
// awu_top.sv: timed wake-up from halt, register file on AXI4-Lite,
// halt sequencing and clock/oscillator controls.
// assumes: the cpu presents fetched opcodes on FETCH_*, the rc clock
// arrives on RC_CLK and is sampled on SYS_CLK.
`timescale 1ns/10ps
`include "awu_cfg.svh"
module awu_top
#(
  parameter int         ADDR_W        = 12,
  parameter bit         ZERO_IMMEDIATE = 1'b0,
  parameter logic [7:0] RC_START_TICKS = `AWU_RC_START_TICKS,
  parameter int         STAB_CYCLES   = `AWU_STAB_CYCLES
)
(
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  input  wire logic              CLK_EN,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic [7:0]        FETCH_OPCODE,
  input  wire logic              FETCH_VALID,
  input  wire logic              EXT_WAKE_IRQ,
  input  wire logic              WDG_ENABLED,
  input  wire logic              WATCHDOG_IN_HALT_OPTION,
  input  wire logic              RC_CLK,
  output logic                   RC_OSC_EN,
  output logic                   CAPTURE_CLK,
  output logic                   MAIN_OSC_EN,
  output logic                   PERIPH_CLK_EN,
  output logic                   CPU_RUN,
  output logic                   WAKEUP_IRQ,
  output logic                   IRQ_MASK_CLR,
  output logic                   WDG_RESET_REQ,
  output logic                   PLAIN_HALT_REQ,
  output logic                   TIMED_HALT_MODE
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (ADDR_W < 10 || STAB_CYCLES < 1 || STAB_CYCLES > 127)
  begin : g_bad_param
    $error("awu_top: ADDR_W or STAB_CYCLES out of range");
  end

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [11:0] b);
    addr_is = (a[ADDR_W-1:2] == (ADDR_W-2)'(b >> 2));
  endfunction

  // ----------------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------------
  awu_pkg::awu_state_t state;
  awu_pkg::awu_state_t next_state;
  logic [7:0]          wakeup_prescaler;
  logic                wakeup_enable;
  logic                wakeup_measure;
  logic                wakeup_flag;
  logic [6:0]          stab_cnt;
  logic                aw_hold;
  logic                w_hold;
  logic [ADDR_W-1:0]   aw_addr;
  logic [31:0]         w_data;
  logic                w_strb0;
  logic                rc_level;
  logic                rc_rise;
  logic                presc_done;
  localparam logic [7:0] CSR_RESET = `AWU_CSR_RESET;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire aw_fire     = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_fire      = S_AXI_WVALID && S_AXI_WREADY;
  wire ar_fire     = S_AXI_ARVALID && S_AXI_ARREADY;
  wire wr_go       = aw_hold && w_hold && !S_AXI_BVALID;
  wire wr_presc    = wr_go && w_strb0 && addr_is(aw_addr, `AWU_PRESC_ADDR);
  wire wr_csr      = wr_go && w_strb0 && addr_is(aw_addr, `AWU_CSR_ADDR);
  wire wr_hit      = addr_is(aw_addr, `AWU_PRESC_ADDR) || addr_is(aw_addr, `AWU_CSR_ADDR);
  wire rd_presc    = addr_is(S_AXI_ARADDR, `AWU_PRESC_ADDR);
  wire rd_csr      = addr_is(S_AXI_ARADDR, `AWU_CSR_ADDR);
  wire csr_read    = ar_fire && rd_csr;
  wire presc_zero  = (w_data[7:0] == `AWU_PRESC_ZERO);
  wire presc_load  = wr_presc && (ZERO_IMMEDIATE || !presc_zero);
  wire in_run      = (state == awu_pkg::AWU_RUN);
  wire in_halt     = (state == awu_pkg::AWU_HALT_WAIT);
  wire halt_fetch  = in_run && FETCH_VALID && (FETCH_OPCODE == `AWU_HALT_OPCODE);
  wire wdg_trip    = halt_fetch && WDG_ENABLED && !WATCHDOG_IN_HALT_OPTION;
  wire timed_entry = halt_fetch && !wdg_trip && wakeup_enable;
  wire plain_entry = halt_fetch && !wdg_trip && !wakeup_enable;
  wire stab_last   = (stab_cnt == 7'(STAB_CYCLES - 1));
  wire next_flag   = presc_done || (wakeup_flag && !csr_read);
  wire [7:0] csr_value = {5'h00, wakeup_flag, wakeup_measure, wakeup_enable};
  wire [7:0] rd_value  = rd_presc ? wakeup_prescaler : (rd_csr ? csr_value : 8'h00);

  assign S_AXI_AWREADY = !aw_hold && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_hold && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // ----------------------------------------------------------------------
  // rc clock sampling and delay counting
  // ----------------------------------------------------------------------
  awu_sync_edge u_rc_sync
  (
    .clk      (SYS_CLK),
    .rst      (RST),
    .ce       (CLK_EN),
    .async_in (RC_CLK),
    .level    (rc_level),
    .rise     (rc_rise)
  );

  // elapsed pulse is born in the clk domain from synchronised rc edges
  awu_prescaler #(.START_TICKS(RC_START_TICKS)) u_presc
  (
    .clk     (SYS_CLK),
    .rst     (RST),
    .ce      (CLK_EN),
    .start   (timed_entry),
    .run     (in_halt || timed_entry),
    .rc_tick (rc_rise),
    .presc   (wakeup_prescaler),
    .done    (presc_done)
  );

  // ----------------------------------------------------------------------
  // halt sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      awu_pkg::AWU_RUN:
        if (timed_entry)
          // a pending interrupt wakes at once since the mask is cleared
          next_state = EXT_WAKE_IRQ ? awu_pkg::AWU_STABILIZE : awu_pkg::AWU_HALT_WAIT;
      awu_pkg::AWU_HALT_WAIT:
        if (presc_done || EXT_WAKE_IRQ)
          next_state = awu_pkg::AWU_STABILIZE;
      awu_pkg::AWU_STABILIZE:
        if (stab_last)
          next_state = awu_pkg::AWU_RUN;
      default:
        next_state = awu_pkg::AWU_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      state    <= awu_pkg::AWU_RUN;
      stab_cnt <= 7'h00;
    end
    else if (CLK_EN)
    begin
      state    <= next_state;
      stab_cnt <= (state == awu_pkg::AWU_STABILIZE) ? stab_cnt + 7'h01 : 7'h00;
    end
  end

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      wakeup_prescaler <= `AWU_PRESC_RESET;
      wakeup_enable    <= CSR_RESET[`AWU_BIT_ENABLE];
      wakeup_measure   <= CSR_RESET[`AWU_BIT_MEASURE];
      wakeup_flag      <= CSR_RESET[`AWU_BIT_FLAG];
    end
    else if (CLK_EN)
    begin
      if (presc_load)
        wakeup_prescaler <= w_data[7:0];
      if (wr_csr)
      begin
        wakeup_enable  <= w_data[`AWU_BIT_ENABLE];
        wakeup_measure <= w_data[`AWU_BIT_MEASURE];
      end
      // flag bit of a write is never used; set wins over read-clear
      wakeup_flag <= next_flag;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= 32'h0000_0000;
      w_strb0      <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `AWU_RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `AWU_RESP_OKAY;
    end
    else if (CLK_EN)
    begin
      if (aw_fire)
      begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (w_fire)
      begin
        w_hold  <= 1'b1;
        w_data  <= S_AXI_WDATA;
        w_strb0 <= S_AXI_WSTRB[0];
      end
      if (wr_go)
      begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit ? `AWU_RESP_OKAY : `AWU_RESP_DECERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      if (ar_fire)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= {24'h00_0000, rd_value};
        S_AXI_RRESP  <= (rd_presc || rd_csr) ? `AWU_RESP_OKAY : `AWU_RESP_DECERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // clock, oscillator and cpu controls
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      RC_OSC_EN   <= 1'b0;
      CAPTURE_CLK <= 1'b0;
    end
    else if (CLK_EN)
    begin
      RC_OSC_EN   <= (next_state == awu_pkg::AWU_HALT_WAIT) || wakeup_measure;
      // measurement path only in run; capture sees the rc clock a few
      // cycles late, which is harmless for period measurement
      CAPTURE_CLK <= wakeup_measure && in_run && rc_level;
    end
  end

  assign MAIN_OSC_EN     = !in_halt;
  assign PERIPH_CLK_EN   = in_run;
  assign CPU_RUN         = in_run;
  assign WAKEUP_IRQ      = wakeup_flag;
  assign IRQ_MASK_CLR    = timed_entry;
  assign WDG_RESET_REQ   = wdg_trip;
  assign PLAIN_HALT_REQ  = plain_entry;
  assign TIMED_HALT_MODE = in_halt;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  AST_TIMED_ENTRY: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CLK_EN && timed_entry) |=> !in_run && !PLAIN_HALT_REQ)
    else $error("timed halt not entered");

  AST_MASK_CLR: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CLK_EN && in_run && next_state != awu_pkg::AWU_RUN) |-> IRQ_MASK_CLR)
    else $error("mask not cleared on halt entry");

  AST_CLOCKS_OFF: assert property (@(posedge SYS_CLK) disable iff (RST)
    in_halt |-> !MAIN_OSC_EN && !PERIPH_CLK_EN && RC_OSC_EN)
    else $error("clocks running in timed halt");

  AST_FLAG_SET: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CLK_EN && presc_done) |=> WAKEUP_IRQ && state == awu_pkg::AWU_STABILIZE)
    else $error("flag or wake missing after delay");

  AST_READ_CLR: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CLK_EN && csr_read && !presc_done) |=> !WAKEUP_IRQ)
    else $error("read did not clear flag");

  AST_FLAG_NOWRITE: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CLK_EN && wr_csr && !presc_done && !csr_read) |=> $stable(wakeup_flag))
    else $error("write changed flag");

  AST_STAB_LEN: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CLK_EN && state == awu_pkg::AWU_STABILIZE && stab_cnt != 7'(STAB_CYCLES - 1))
      |=> state == awu_pkg::AWU_STABILIZE)
    else $error("stabilisation delay wrong");

  AST_WDG_TRIP: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CLK_EN && halt_fetch && WDG_ENABLED && !WATCHDOG_IN_HALT_OPTION)
      |-> WDG_RESET_REQ ##1 in_run)
    else $error("watchdog halt not turned into reset");

  AST_EXT_WAKE: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CLK_EN && in_halt && EXT_WAKE_IRQ) |=> state == awu_pkg::AWU_STABILIZE)
    else $error("external interrupt did not wake");

  AST_ZERO_KEEP: assert property (@(posedge SYS_CLK) disable iff (RST)
    (CLK_EN && wr_presc && presc_zero && !ZERO_IMMEDIATE) |=> $stable(wakeup_prescaler))
    else $error("zero prescaler write accepted");

endmodule

// ===== inc/awu_cfg.svh
// awu_cfg.svh: offsets, field positions, reset values and timing counts
// of the timed-halt wake-up block.
// assumes: included by bare name; holds definitions only.
`ifndef AWU_CFG_SVH
`define AWU_CFG_SVH

// ----------------------------------------------------------------------
// register indices (printed offsets) and byte addresses on the bus
// ----------------------------------------------------------------------
`define AWU_PRESC_IDX      12'h049
`define AWU_CSR_IDX        12'h04A
`define AWU_PRESC_ADDR     (`AWU_PRESC_IDX << 2)
`define AWU_CSR_ADDR       (`AWU_CSR_IDX << 2)

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define AWU_BIT_ENABLE     0
`define AWU_BIT_MEASURE    1
`define AWU_BIT_FLAG       2
`define AWU_CSR_RESET      8'h00
`define AWU_PRESC_RESET    8'hFF
`define AWU_PRESC_ZERO     8'h00

// ----------------------------------------------------------------------
// instruction and timing
// ----------------------------------------------------------------------
`define AWU_HALT_OPCODE    8'h8E
`define AWU_FIXED_DIV      64
`define AWU_STAB_CYCLES    64
`define AWU_RC_START_TICKS 8'h04

// ----------------------------------------------------------------------
// bus response codes
// ----------------------------------------------------------------------
`define AWU_RESP_OKAY      2'h0
`define AWU_RESP_DECERR    2'h3

`endif

// ===== inc/awu_pkg.sv
// awu_pkg.sv: types shared by the timed-halt wake-up block.
// assumes: constants live in awu_cfg.svh.
package awu_pkg;

  typedef enum logic [1:0] {
    AWU_RUN       = 2'b00,
    AWU_HALT_WAIT = 2'b01,
    AWU_STABILIZE = 2'b10
  } awu_state_t;

endpackage

// ===== test/awu_cpu_model.sv
// awu_cpu_model.sv: cpu fetch stream and wake-up rc oscillator beside the
// timed wake-up block.
// assumes: shares the block's clock; halt_go is held for one cycle.
`timescale 1ns/10ps
`include "awu_cfg.svh"
module awu_cpu_model
#(
  parameter int RC_HALF = 3
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       halt_go,
  input  wire logic       cpu_run,
  input  wire logic       rc_en,
  output logic [7:0]      fetch_op,
  output logic            fetch_vld,
  output logic            rc_clk
);
  logic [7:0] seq;
  int         ph;

  // --------------------------------------------------------------------
  // fetch stream: plain bytes skip the halt opcode, stalled cpu scrambles
  // --------------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seq       <= 8'h00;
      fetch_op  <= 8'h00;
      fetch_vld <= 1'b0;
    end
    else
    begin
      seq <= seq + 8'h01;
      fetch_vld <= cpu_run;
      if (!cpu_run)
        fetch_op <= ~fetch_op;
      else if (halt_go)
        fetch_op <= `AWU_HALT_OPCODE;
      else
        fetch_op <= (seq == `AWU_HALT_OPCODE) ? 8'h00 : seq;
    end
  end

  // --------------------------------------------------------------------
  // rc oscillator: stands low while disabled, slower than clk/2
  // --------------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst || !rc_en)
    begin
      ph     <= 0;
      rc_clk <= 1'b0;
    end
    else if (ph == RC_HALF - 1)
    begin
      ph     <= 0;
      rc_clk <= ~rc_clk;
    end
    else
      ph <= ph + 1;
  end
endmodule

// ===== test/awu_top_test.sv
// awu_top_test.sv: self-checking bench of the timed wake-up block.
// assumes: awu_cpu_model stands for the cpu fetch stream and rc oscillator.
`timescale 1ns/10ps
`include "awu_cfg.svh"
module awu_top_test;
  logic        clk, rst, awv, wv, bry, arv, rry, ext, wdg, wopt, go;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdata;
  logic [3:0]  ws;
  logic        awr, wrdy, bv, arr, rv, rcen, cap, mosc, pclk, crun, irq, mclr;
  logic        wrst, phalt, thm, fv, rc, rcq, capq;
  logic [1:0]  bresp, rresp;
  logic [7:0]  fop;
  logic [31:0] seed = 32'h49;
  int          errors = 0, checks_done = 0, m_csr = 0, m_presc = 255;
  int          n_mask = 0, n_plain = 0, n_wdg = 0, n_rc = 0, n_cap = 0;

  awu_top dut
  (
    .SYS_CLK(clk), .RST(rst), .CLK_EN(1'b1), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .FETCH_OPCODE(fop),
    .FETCH_VALID(fv), .EXT_WAKE_IRQ(ext), .WDG_ENABLED(wdg), .WATCHDOG_IN_HALT_OPTION(wopt),
    .RC_CLK(rc), .RC_OSC_EN(rcen), .CAPTURE_CLK(cap), .MAIN_OSC_EN(mosc),
    .PERIPH_CLK_EN(pclk), .CPU_RUN(crun), .WAKEUP_IRQ(irq), .IRQ_MASK_CLR(mclr),
    .WDG_RESET_REQ(wrst), .PLAIN_HALT_REQ(phalt), .TIMED_HALT_MODE(thm)
  );
  awu_cpu_model #(.RC_HALF(3)) cpu
  (
    .clk(clk), .rst(rst), .halt_go(go), .cpu_run(crun), .rc_en(rcen),
    .fetch_op(fop), .fetch_vld(fv), .rc_clk(rc)
  );

  initial clk = 1'b0;
  always #20 clk = ~clk;

  // --------------------------------------------------------------------
  // event counters sampled at each rising edge
  // --------------------------------------------------------------------
  always @(posedge clk)
  begin
    rcq <= rc;
    capq <= cap;
    if (mclr === 1'b1) n_mask <= n_mask + 1;
    if (phalt === 1'b1) n_plain <= n_plain + 1;
    if (wrst === 1'b1) n_wdg <= n_wdg + 1;
    if (thm === 1'b1 && rc === 1'b1 && rcq === 1'b0) n_rc <= n_rc + 1;
    if (cap === 1'b1 && capq === 1'b0) n_cap <= n_cap + 1;
  end

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input int v, input int lo, input int hi);
    checks_done++;
    if (v < lo || v > hi)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask

  // ready is sampled at the falling edge, where it has settled
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int   n;
    logic ah, wh, ad, wdn, bh;
    n = 0;
    ad = 1'b0;
    wdn = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!(ad && wdn) && n < 100)
    begin
      @(negedge clk);
      ah = awr & ~ad;
      wh = wrdy & ~wdn;
      @(posedge clk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      ad |= ah;
      wdn |= wh;
      n++;
    end
    bry <= 1'b1;
    do
    begin
      @(negedge clk);
      bh = bv;
      r = bresp;
      @(posedge clk);
      n++;
    end
    while (bh !== 1'b1 && n < 200);
    bry <= 1'b0;
    if (n >= 200) errors++;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic h;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do
    begin
      @(negedge clk);
      h = arr;
      @(posedge clk);
      n++;
    end
    while (h !== 1'b1 && n < 100);
    arv <= 1'b0;
    rry <= 1'b1;
    do
    begin
      @(negedge clk);
      h = rv;
      d = rdata;
      r = rresp;
      @(posedge clk);
      n++;
    end
    while (h !== 1'b1 && n < 200);
    rry <= 1'b0;
    if (n >= 200) errors++;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'hF, r);
    chk(r, `AWU_RESP_OKAY);
    if (a == `AWU_CSR_ADDR) m_csr = (m_csr & 4) | (d & 3);
    else if (d != 0) m_presc = d;
  endtask

  // a control/status read hands back the flag and then clears it in the model
  task automatic rd_reg(input logic [11:0] a);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(r, `AWU_RESP_OKAY);
    chk(d, (a == `AWU_CSR_ADDR) ? m_csr : m_presc);
    if (a == `AWU_CSR_ADDR) m_csr = m_csr & 3;
  endtask

  task automatic halt_fetch();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #1600000;
    errors++;
    finish_test();
  end

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial
  begin
    int          k, k2, p, n;
    logic [31:0] v, d;
    logic [1:0]  r;
    {awv, wv, bry, arv, rry, ext, wdg, go, wopt} = 9'h001;
    {awa, ara, wd, ws} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`AWU_PRESC_ADDR);
    rd_reg(`AWU_CSR_ADDR);
    axi_rd(12'h130, d, r);
    chk(r, `AWU_RESP_DECERR);
    axi_wr(12'h000, 8'h55, 4'hF, r);
    chk(r, `AWU_RESP_DECERR);
    axi_wr(`AWU_PRESC_ADDR, 8'h55, 4'h0, r);
    chk(r, `AWU_RESP_OKAY);
    rd_reg(`AWU_PRESC_ADDR);
    for (int i = 0; i < 4; i++)
    begin
      v = rnd();
      wr_reg(`AWU_CSR_ADDR, v[7:0]);
      rd_reg(`AWU_CSR_ADDR);
      wr_reg(`AWU_PRESC_ADDR, v[15:8]);
      rd_reg(`AWU_PRESC_ADDR);
    end
    wr_reg(`AWU_PRESC_ADDR, 8'h00);
    rd_reg(`AWU_PRESC_ADDR);
    wr_reg(`AWU_CSR_ADDR, 8'h02);
    k = n_cap;
    repeat (80) @(posedge clk);
    chk(rcen, 1'b1);
    chk_in(n_cap - k, 5, 20);
    wr_reg(`AWU_CSR_ADDR, 8'h00);
    k = n_plain;
    halt_fetch();
    chk_in(n_plain - k, 1, 1);
    chk(thm, 1'b0);
    wdg <= 1'b1;
    wopt <= 1'b0;
    wr_reg(`AWU_CSR_ADDR, 8'h01);
    k = n_wdg;
    k2 = n_mask;
    halt_fetch();
    chk_in(n_wdg - k, 1, 1);
    chk_in(n_mask - k2, 0, 0);
    wdg <= 1'b0;
    ext <= 1'b0;
    p = 1 + (rnd() % 2);
    wr_reg(`AWU_PRESC_ADDR, p[7:0]);
    k = n_mask;
    k2 = n_rc;
    halt_fetch();
    chk_in(n_mask - k, 1, 1);
    chk({thm, mosc, pclk, rcen}, 4'b1001);
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
    p = `AWU_RC_START_TICKS + `AWU_FIXED_DIV * p;
    chk_in(n_rc - k2, p - 1, p + 1);
    chk(mosc, 1'b1);
    n = 0;
    while (crun !== 1'b1 && n < 200) begin @(negedge clk); n++; end
    chk_in(n, `AWU_STAB_CYCLES - 1, `AWU_STAB_CYCLES + 1);
    wr_reg(`AWU_CSR_ADDR, 8'h01);
    m_csr = m_csr | 4;
    rd_reg(`AWU_CSR_ADDR);
    chk(irq, 1'b0);
    rd_reg(`AWU_CSR_ADDR);
    // interrupt already pending at halt entry: straight to stabilisation
    k = n_mask;
    ext <= 1'b1;
    halt_fetch();
    chk_in(n_mask - k, 1, 1);
    chk({thm, crun, mosc}, 3'b001);
    n = 0;
    while (crun !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    ext <= 1'b0;
    chk({crun, irq}, 2'b10);
    wr_reg(`AWU_PRESC_ADDR, 8'hFF);
    halt_fetch();
    ext <= 1'b1;
    n = 0;
    while (crun !== 1'b1 && n < 200) begin @(negedge clk); n++; end
    @(posedge clk);
    ext <= 1'b0;
    chk({crun, irq}, 2'b10);
    rd_reg(`AWU_CSR_ADDR);
    finish_test();
  end
endmodule
